// *** hw/spd_pkg.sv ***
// shared constants, types and register map of the serial packet delineator
package spd_pkg;
    // timing
    localparam int CLK_HZ = 25_000_000;
    localparam int TICK_US = 1;
    localparam int TICK_CYC = TICK_US * (CLK_HZ / 1_000_000);
    localparam int US_PER_MS = 1000;
    localparam logic [9:0] EOL_MIN_MS = 10'h001;
    localparam logic [18:0] RATE_MIN_US = 19'h003e8;
    localparam logic [18:0] RATE_MAX_US = 19'h7a120;
    localparam logic [15:0] BAUD_MIN_DIV = 16'h0010;
    // register byte offsets
    localparam logic [7:0] OFF_CFG = 8'h00;
    localparam logic [7:0] OFF_EOL = 8'h04;
    localparam logic [7:0] OFF_RATE = 8'h08;
    localparam logic [7:0] OFF_BAUD = 8'h0c;
    localparam logic [7:0] OFF_TEXT = 8'h10;
    localparam logic [7:0] OFF_TLEN = 8'h14;
    localparam logic [7:0] OFF_CMD = 8'h18;
    localparam logic [7:0] OFF_STAT = 8'h1c;
    localparam logic [7:0] OFF_ACT = 8'h20;
    // field positions
    localparam int CF_METHOD = 0;
    localparam int CF_DELIM = 2;
    localparam int CF_DBITS = 5;
    localparam int CF_PARITY = 7;
    localparam int CF_FLOW = 10;
    localparam int CF_STOP2 = 11;
    localparam int CMD_SAVE = 0;
    localparam int CMD_CANCEL = 1;
    localparam int ST_OVF = 0;
    localparam int ST_PERR = 1;
    localparam int ST_FERR = 2;
    localparam int ST_HELD = 3;
    localparam int ST_PKTCNT = 16;
    // delimiter codes
    localparam logic [7:0] CH_CR = 8'h0d;
    localparam logic [7:0] CH_ESC = 8'h1b;
    localparam logic [7:0] CH_LF = 8'h0a;
    localparam logic [7:0] CH_NUL = 8'h00;
    localparam logic [7:0] CH_SPC = 8'h20;
    localparam logic [7:0] CH_TAB = 8'h09;
    // buffering
    localparam int FIFO_DEPTH = 16;
    localparam int FIFO_W = 9;

    typedef enum logic [1:0] {METH_NONE, METH_CHAR, METH_GAP} spd_method_t;
    typedef enum logic [2:0] {DL_TEXT, DL_CR, DL_ESC, DL_LF, DL_NUL, DL_SPC, DL_TAB} spd_delim_t;
    typedef enum logic [2:0] {PAR_NONE, PAR_EVEN, PAR_ODD, PAR_ONE, PAR_ZERO} spd_parity_t;
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP1, RX_STOP2} spd_rx_t;

    typedef struct packed {
        spd_method_t method;
        spd_delim_t delim;
        logic [1:0] dbits;
        spd_parity_t parity;
        logic flow;
        logic stop2;
        logic [9:0] eol_ms;
        logic [18:0] rate_us;
        logic [15:0] baud_div;
        logic [31:0] text;
        logic [2:0] text_len;
    } spd_cfg_t;

    localparam spd_cfg_t CFG_RST = '{
        method: METH_NONE, delim: DL_CR, dbits: 2'h3, parity: PAR_NONE,
        flow: 1'b0, stop2: 1'b0, eol_ms: 10'h00a, rate_us: 19'h02710,
        baud_div: 16'h00d9, text: 32'h0000000d, text_len: 3'h1};
endpackage : spd_pkg

// *** hw/spd_stream_if.sv ***
// valid/ready byte stream between the delineator and its buffer
`timescale 1ns/100ps
`default_nettype none
interface spd_stream_if #(parameter int W = 9);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport source(output valid, output data, input ready);
    modport sink(input valid, input data, output ready);
endinterface : spd_stream_if
`default_nettype wire

// *** hw/spd_fifo.sv ***
// flip-flop fifo with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none
module spd_fifo #(
    parameter int W = 9,
    parameter int D = 16
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // streams
    spd_stream_if.sink wr,
    spd_stream_if.source rd
);
    localparam int AW = $clog2(D);

    if (D < 2 || (D & (D - 1)) != 0) begin : g_chk
        $error("spd_fifo: depth must be a power of two, at least 2");
    end

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0] rp;
        logic [AW-1:0] wp;
        logic [AW:0] cnt;
    } spd_fifo_st_t;

    spd_fifo_st_t s;
    spd_fifo_st_t next_s;
    logic do_wr;
    logic do_rd;

    assign wr.ready = (s.cnt != (AW + 1)'(D));
    assign rd.valid = (s.cnt != '0);
    assign rd.data = s.mem[s.rp];

    always_comb begin
        next_s = s;
        do_wr = wr.valid & wr.ready;
        do_rd = rd.valid & rd.ready;
        if (do_wr) begin
            next_s.mem[s.wp] = wr.data;
            next_s.wp = s.wp + 1'b1;
        end
        if (do_rd) begin
            next_s.rp = s.rp + 1'b1;
        end
        if (do_wr && !do_rd) begin
            next_s.cnt = s.cnt + 1'b1;
        end else if (do_rd && !do_wr) begin
            next_s.cnt = s.cnt - 1'b1;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end
endmodule : spd_fifo
`default_nettype wire

// *** hw/spd_delineator.sv ***
// serial receiver that cuts characters into packets for the network side
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - no method: packet spans gap to gap
// - fixed delimiters CR, ESC, LF, NUL, SPC, TAB
// - user text string may be the delimiter
// - time-gap mode closes after idle milliseconds
// - idle time has a lower limit
// - packet-rate idle gap closes the packet
// - packet rate in microseconds, 1000 to 500000
// - bit rate selectable, partner must match
// - 5 to 8 data bits, partner matches
// - parity none/even/odd/one/zero, partner matches
// - none or hardware handshake, partner matches
// - one or two stop bits, partner matches
// - edits apply only on save
// - cancel drops edits, active kept
module spd_delineator #(
    parameter int FIFO_DEPTH = spd_pkg::FIFO_DEPTH
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // avalon-mm slave
    input wire logic [7:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // serial pins
    input wire logic rxd_i,
    output logic rts_n_o,
    // packet stream to the network side
    output logic [7:0] pkt_data_o,
    output logic pkt_last_o,
    output logic pkt_valid_o,
    input wire logic pkt_ready_i
);
    typedef struct packed {
        spd_pkg::spd_cfg_t pend;
        spd_pkg::spd_cfg_t act;
        logic ack;
        logic [31:0] rdata;
        logic rx_s1;
        logic rx_s2;
        spd_pkg::spd_rx_t rx_st;
        logic [15:0] div_cnt;
        logic [2:0] bit_cnt;
        logic [7:0] shreg;
        logic par_acc;
        logic [7:0] held;
        logic held_v;
        logic close_pend;
        logic [31:0] hist;
        logic [19:0] idle_us;
        logic [4:0] tick_cnt;
        logic ovf;
        logic perr;
        logic ferr;
        logic [15:0] pkt_cnt;
    } spd_state_t;

    spd_state_t s;
    spd_state_t next_s;
    logic tick;
    logic char_v;
    logic [7:0] char_b;
    logic [31:0] new_hist;
    logic gap_hit;
    logic exp_par;
    logic [7:0] a;
    logic [31:0] wd;
    logic [2:0] clr;

    spd_stream_if #(.W(spd_pkg::FIFO_W)) in_s();
    spd_stream_if #(.W(spd_pkg::FIFO_W)) out_s();

    spd_fifo #(.W(spd_pkg::FIFO_W), .D(FIFO_DEPTH)) u_fifo (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wr(in_s.sink),
        .rd(out_s.source)
    );

    function automatic logic [31:0] cfg_word(input spd_pkg::spd_cfg_t c);
        logic [31:0] w;
        w = '0;
        w[spd_pkg::CF_METHOD +: 2] = c.method;
        w[spd_pkg::CF_DELIM +: 3] = c.delim;
        w[spd_pkg::CF_DBITS +: 2] = c.dbits;
        w[spd_pkg::CF_PARITY +: 3] = c.parity;
        w[spd_pkg::CF_FLOW] = c.flow;
        w[spd_pkg::CF_STOP2] = c.stop2;
        return w;
    endfunction : cfg_word

    function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return r;
    endfunction : be_merge

    // limits applied as the edits become active
    function automatic spd_pkg::spd_cfg_t clamp(input spd_pkg::spd_cfg_t c);
        spd_pkg::spd_cfg_t r;
        r = c;
        if (c.eol_ms < spd_pkg::EOL_MIN_MS) r.eol_ms = spd_pkg::EOL_MIN_MS;
        if (c.rate_us < spd_pkg::RATE_MIN_US) r.rate_us = spd_pkg::RATE_MIN_US;
        if (c.rate_us > spd_pkg::RATE_MAX_US) r.rate_us = spd_pkg::RATE_MAX_US;
        if (c.baud_div < spd_pkg::BAUD_MIN_DIV) r.baud_div = spd_pkg::BAUD_MIN_DIV;
        if (c.text_len > 3'h4) r.text_len = 3'h4;
        return r;
    endfunction : clamp

    function automatic logic [7:0] delim_code(input spd_pkg::spd_delim_t d);
        case (d)
            spd_pkg::DL_CR: return spd_pkg::CH_CR;
            spd_pkg::DL_ESC: return spd_pkg::CH_ESC;
            spd_pkg::DL_LF: return spd_pkg::CH_LF;
            spd_pkg::DL_SPC: return spd_pkg::CH_SPC;
            spd_pkg::DL_TAB: return spd_pkg::CH_TAB;
            default: return spd_pkg::CH_NUL;
        endcase
    endfunction : delim_code

    // text byte 0 is the final character of the sequence
    function automatic logic text_hit(input logic [31:0] h, input logic [31:0] t,
                                      input logic [2:0] len);
        logic hit;
        hit = (len != 3'h0);
        for (int i = 0; i < 4; i++) begin
            if (3'(i) < len && h[8*i +: 8] != t[8*i +: 8]) begin
                hit = 1'b0;
            end
        end
        return hit;
    endfunction : text_hit

    assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~s.ack;
    assign avs_readdata_o = s.rdata;
    // handshake asks the partner to pause once the buffer is full
    assign rts_n_o = s.act.flow & ~in_s.ready;
    assign pkt_valid_o = out_s.valid;
    assign pkt_data_o = out_s.data[7:0];
    assign pkt_last_o = out_s.data[8];
    assign out_s.ready = pkt_ready_i;

    always_comb begin
        next_s = s;
        tick = 1'b0;
        char_v = 1'b0;
        in_s.valid = 1'b0;
        in_s.data = '0;
        a = {avs_address_i[7:2], 2'b00};
        wd = avs_writedata_i;
        clr = '0;
        exp_par = 1'b0;
        // pin synchroniser
        next_s.rx_s1 = rxd_i;
        next_s.rx_s2 = s.rx_s1;

        // bus: one wait cycle, then the access completes
        next_s.ack = (avs_read_i | avs_write_i) & ~s.ack;
        if (avs_read_i && !s.ack) begin
            if (a == spd_pkg::OFF_CFG) begin
                next_s.rdata = cfg_word(s.pend);
            end else if (a == spd_pkg::OFF_EOL) begin
                next_s.rdata = 32'(s.pend.eol_ms);
            end else if (a == spd_pkg::OFF_RATE) begin
                next_s.rdata = 32'(s.pend.rate_us);
            end else if (a == spd_pkg::OFF_BAUD) begin
                next_s.rdata = 32'(s.pend.baud_div);
            end else if (a == spd_pkg::OFF_TEXT) begin
                next_s.rdata = s.pend.text;
            end else if (a == spd_pkg::OFF_TLEN) begin
                next_s.rdata = 32'(s.pend.text_len);
            end else if (a == spd_pkg::OFF_STAT) begin
                next_s.rdata = '0;
                next_s.rdata[spd_pkg::ST_OVF] = s.ovf;
                next_s.rdata[spd_pkg::ST_PERR] = s.perr;
                next_s.rdata[spd_pkg::ST_FERR] = s.ferr;
                next_s.rdata[spd_pkg::ST_HELD] = s.held_v;
                next_s.rdata[spd_pkg::ST_PKTCNT +: 16] = s.pkt_cnt;
            end else if (a == spd_pkg::OFF_ACT) begin
                next_s.rdata = cfg_word(s.act);
            end else begin
                next_s.rdata = '0;
            end
        end
        if (avs_write_i && s.ack) begin
            if (a == spd_pkg::OFF_CFG) begin
                wd = be_merge(cfg_word(s.pend), avs_writedata_i, avs_byteenable_i);
                next_s.pend.method = spd_pkg::spd_method_t'(wd[spd_pkg::CF_METHOD +: 2]);
                next_s.pend.delim = spd_pkg::spd_delim_t'(wd[spd_pkg::CF_DELIM +: 3]);
                next_s.pend.dbits = wd[spd_pkg::CF_DBITS +: 2];
                next_s.pend.parity = spd_pkg::spd_parity_t'(wd[spd_pkg::CF_PARITY +: 3]);
                next_s.pend.flow = wd[spd_pkg::CF_FLOW];
                next_s.pend.stop2 = wd[spd_pkg::CF_STOP2];
            end else if (a == spd_pkg::OFF_EOL) begin
                wd = be_merge(32'(s.pend.eol_ms), avs_writedata_i, avs_byteenable_i);
                next_s.pend.eol_ms = wd[9:0];
            end else if (a == spd_pkg::OFF_RATE) begin
                wd = be_merge(32'(s.pend.rate_us), avs_writedata_i, avs_byteenable_i);
                next_s.pend.rate_us = wd[18:0];
            end else if (a == spd_pkg::OFF_BAUD) begin
                wd = be_merge(32'(s.pend.baud_div), avs_writedata_i, avs_byteenable_i);
                next_s.pend.baud_div = wd[15:0];
            end else if (a == spd_pkg::OFF_TEXT) begin
                next_s.pend.text = be_merge(s.pend.text, avs_writedata_i, avs_byteenable_i);
            end else if (a == spd_pkg::OFF_TLEN) begin
                if (avs_byteenable_i[0]) next_s.pend.text_len = avs_writedata_i[2:0];
            end else if (a == spd_pkg::OFF_CMD) begin
                if (avs_byteenable_i[0] && avs_writedata_i[spd_pkg::CMD_SAVE]) begin
                    next_s.act = clamp(s.pend);
                end else if (avs_byteenable_i[0] && avs_writedata_i[spd_pkg::CMD_CANCEL]) begin
                    next_s.pend = s.act;
                end
            end else if (a == spd_pkg::OFF_STAT) begin
                clr = avs_writedata_i[2:0] & {3{avs_byteenable_i[0]}};
            end
        end
        // clears first; later sets in this process win
        if (clr[spd_pkg::ST_OVF]) next_s.ovf = 1'b0;
        if (clr[spd_pkg::ST_PERR]) next_s.perr = 1'b0;
        if (clr[spd_pkg::ST_FERR]) next_s.ferr = 1'b0;

        // microsecond tick and saturating idle time
        if (s.tick_cnt == 5'(spd_pkg::TICK_CYC - 1)) begin
            tick = 1'b1;
            next_s.tick_cnt = '0;
        end else begin
            next_s.tick_cnt = s.tick_cnt + 1'b1;
        end
        if (tick && s.idle_us != '1) next_s.idle_us = s.idle_us + 1'b1;

        // receiver, sampling at bit centres
        case (s.act.parity)
            spd_pkg::PAR_EVEN: exp_par = s.par_acc;
            spd_pkg::PAR_ODD: exp_par = ~s.par_acc;
            spd_pkg::PAR_ONE: exp_par = 1'b1;
            default: exp_par = 1'b0;
        endcase
        if (s.rx_st != spd_pkg::RX_IDLE && s.div_cnt != '0) begin
            next_s.div_cnt = s.div_cnt - 1'b1;
        end else begin
            next_s.div_cnt = s.act.baud_div - 1'b1;
            case (s.rx_st)
                spd_pkg::RX_IDLE: begin
                    next_s.div_cnt = {1'b0, s.act.baud_div[15:1]};
                    if (!s.rx_s2) next_s.rx_st = spd_pkg::RX_START;
                end
                spd_pkg::RX_START: begin
                    next_s.bit_cnt = '0;
                    next_s.par_acc = 1'b0;
                    next_s.rx_st = s.rx_s2 ? spd_pkg::RX_IDLE : spd_pkg::RX_DATA;
                end
                spd_pkg::RX_DATA: begin
                    next_s.shreg = {s.rx_s2, s.shreg[7:1]};
                    next_s.par_acc = s.par_acc ^ s.rx_s2;
                    next_s.bit_cnt = s.bit_cnt + 1'b1;
                    if (s.bit_cnt == {1'b0, s.act.dbits} + 3'h4) begin
                        next_s.rx_st = (s.act.parity == spd_pkg::PAR_NONE) ?
                                       spd_pkg::RX_STOP1 : spd_pkg::RX_PAR;
                    end
                end
                spd_pkg::RX_PAR: begin
                    if (s.rx_s2 != exp_par) next_s.perr = 1'b1;
                    next_s.rx_st = spd_pkg::RX_STOP1;
                end
                spd_pkg::RX_STOP1: begin
                    if (!s.rx_s2) next_s.ferr = 1'b1;
                    if (s.act.stop2 && s.rx_s2) begin
                        next_s.rx_st = spd_pkg::RX_STOP2;
                    end else begin
                        char_v = 1'b1;
                        next_s.rx_st = spd_pkg::RX_IDLE;
                    end
                end
                default: begin
                    if (!s.rx_s2) next_s.ferr = 1'b1;
                    char_v = 1'b1;
                    next_s.rx_st = spd_pkg::RX_IDLE;
                end
            endcase
        end
        char_b = s.shreg >> (2'h3 - s.act.dbits);
        new_hist = {s.hist[23:0], char_b};

        // one character is held back so the closing byte can carry last
        gap_hit = (s.idle_us >= 20'(s.act.rate_us)) ||
                  (s.act.method == spd_pkg::METH_GAP &&
                   s.idle_us >= 20'(s.act.eol_ms * spd_pkg::US_PER_MS));
        if (s.close_pend) begin
            in_s.valid = 1'b1;
            in_s.data = {1'b1, s.held};
            next_s.held_v = 1'b0;
            next_s.close_pend = 1'b0;
        end else if (char_v) begin
            in_s.valid = s.held_v;
            in_s.data = {1'b0, s.held};
            next_s.held = char_b;
            next_s.held_v = 1'b1;
            next_s.idle_us = '0;
            next_s.hist = new_hist;
            if (s.act.method == spd_pkg::METH_CHAR) begin
                if (s.act.delim == spd_pkg::DL_TEXT) begin
                    next_s.close_pend = text_hit(new_hist, s.act.text, s.act.text_len);
                end else begin
                    next_s.close_pend = (char_b == delim_code(s.act.delim));
                end
            end
        end else if (s.held_v && gap_hit) begin
            // with no method the gap alone bounds the frame
            in_s.valid = 1'b1;
            in_s.data = {1'b1, s.held};
            next_s.held_v = 1'b0;
        end
        if (in_s.valid && in_s.data[8]) begin
            next_s.hist = '0;
            next_s.pkt_cnt = s.pkt_cnt + 1'b1;
        end
        // a full buffer drops the byte rather than stall the line
        if (in_s.valid && !in_s.ready) next_s.ovf = 1'b1;
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s <= '0;
            s.pend <= spd_pkg::CFG_RST;
            s.act <= spd_pkg::CFG_RST;
            s.rx_s1 <= 1'b1;
            s.rx_s2 <= 1'b1;
        end else begin
            s <= next_s;
        end
    end
endmodule : spd_delineator
`default_nettype wire

// *** dv/spd_serial_dev.sv ***
// model of the locally attached serial device driving the receive pin
`timescale 1ns/100ps
`default_nettype none
module spd_serial_dev (
    // clock
    input wire logic clk_i,
    // serial pins
    input wire logic rts_n_i,
    output logic rxd_o
);
    initial rxd_o = 1'b1;

    task automatic bit_out(input logic b, input int div);
        rxd_o <= b;
        repeat (div) @(posedge clk_i);
    endtask : bit_out

    // chars handed in must fit the data width, so parity covers d as a whole
    task automatic send(input logic [7:0] d, input logic [31:0] cw, input int div);
        int n;
        n = cw[6:5] + 5;
        while (cw[10] && rts_n_i) @(posedge clk_i);
        bit_out(1'b0, div);
        for (int i = 0; i < n; i++) bit_out(d[i], div);
        case (cw[9:7])
            3'h1: bit_out(^d, div);
            3'h2: bit_out(~^d, div);
            3'h3: bit_out(1'b1, div);
            3'h4: bit_out(1'b0, div);
            default: ;
        endcase
        bit_out(1'b1, cw[11] ? 2 * div : div);
    endtask : send
endmodule : spd_serial_dev
`default_nettype wire

// *** dv/spd_delineator_asserts.sv ***
// concurrent checks on the delineator's top ports
`timescale 1ns/100ps
`default_nettype none
module spd_delineator_asserts (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // register bus
    input wire logic [7:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    // serial pins
    input wire logic rxd_i,
    input wire logic rts_n_o,
    // packet stream
    input wire logic [7:0] pkt_data_o,
    input wire logic pkt_last_o,
    input wire logic pkt_valid_o,
    input wire logic pkt_ready_i
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    first_wait_a: assert property ($rose(avs_read_i || avs_write_i) |-> avs_waitrequest_o)
        else $error("first request cycle not stalled");
    one_wait_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
        |=> !avs_waitrequest_o) else $error("more than one wait cycle");
    idle_nowait_a: assert property (!(avs_read_i || avs_write_i) |-> !avs_waitrequest_o)
        else $error("stall without request");
    cmd_zero_a: assert property (avs_read_i && !avs_waitrequest_o && avs_address_i[7:2] == 6'h06
        |-> avs_readdata_o == 32'h0) else $error("command word reads nonzero");
    unmapped_zero_a: assert property (avs_read_i && !avs_waitrequest_o && avs_address_i[7:2] > 6'h08
        |-> avs_readdata_o == 32'h0) else $error("unmapped word reads nonzero");
    rdata_hold_a: assert property (!avs_read_i |=> $stable(avs_readdata_o))
        else $error("read data moved without a read");
    pkt_hold_a: assert property (pkt_valid_o && !pkt_ready_i
        |=> pkt_valid_o && $stable({pkt_last_o, pkt_data_o})) else $error("stalled byte changed");
    rts_room_a: assert property (!pkt_valid_o |-> !rts_n_o)
        else $error("sender throttled with empty buffer");
endmodule : spd_delineator_asserts
`default_nettype wire

// *** dv/testbench.sv ***
// self-checking bench for the serial packet delineator
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] avs_address_i = 8'h00;
    logic avs_read_i = 1'b0;
    logic avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0;
    logic pkt_ready_i = 1'b0;
    logic [31:0] avs_readdata_o, rdata, cw;
    logic avs_waitrequest_o, rxd_i, rts_n_o, pkt_last_o, pkt_valid_o;
    logic [7:0] pkt_data_o;
    int num_errors = 0;
    int comparisons = 0;
    int cycles = 0;
    int div = 16;
    int waited;
    logic [7:0] codes [6] = '{8'h0d, 8'h1b, 8'h0a, 8'h00, 8'h20, 8'h09};

    always #20 clk_i = ~clk_i;

    spd_delineator spd_delineator_inst (
        .clk_i(clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
        .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(4'hf),
        .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .rxd_i(rxd_i),
        .rts_n_o(rts_n_o), .pkt_data_o(pkt_data_o), .pkt_last_o(pkt_last_o),
        .pkt_valid_o(pkt_valid_o), .pkt_ready_i(pkt_ready_i));
    spd_serial_dev spd_serial_dev_inst (.clk_i(clk_i), .rts_n_i(rts_n_o), .rxd_o(rxd_i));

    task automatic check(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : check

    // request held until the edge that sees waitrequest low; data taken at that edge
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_write_i <= wr;
        avs_read_i <= ~wr;
        do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
        rdata = avs_readdata_o;
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
    endtask : bus

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        check(rdata, e);
    endtask : rd

    task automatic setcfg(input logic [31:0] w);
        cw = w;
        bus(1'b1, 8'h00, w);
        bus(1'b1, 8'h18, 32'h1);
        rd(8'h20, w);
    endtask : setcfg

    task automatic tx(input logic [7:0] d);
        spd_serial_dev_inst.send(d, cw, div);
    endtask : tx

    // ready stays low until the byte has been compared, so nothing slips past
    task automatic get(input logic [7:0] d, input logic l, input int maxw);
        waited = 0;
        @(posedge clk_i);
        #1;
        while (pkt_valid_o !== 1'b1 && waited < maxw) begin
            @(posedge clk_i);
            #1;
            waited++;
        end
        check({22'h0, pkt_valid_o, pkt_last_o, pkt_data_o}, {22'h0, 1'b1, l, d});
        @(posedge clk_i);
        pkt_ready_i <= 1'b1;
        @(posedge clk_i);
        pkt_ready_i <= 1'b0;
    endtask : get

    task automatic conclude();
        $display("num_errors=%0d comparisons=%0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : conclude

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 90000) begin
            num_errors++;
            conclude();
        end
    end

    initial begin
        cw = 32'h64;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(8'h20, 32'h64);
        rd(8'h08, 32'h2710);
        rd(8'h30, 32'h0);
        bus(1'b1, 8'h00, 32'h1);
        rd(8'h20, 32'h64);
        bus(1'b1, 8'h18, 32'h2);
        rd(8'h00, 32'h64);
        bus(1'b1, 8'h04, 32'h0);
        bus(1'b1, 8'h08, 32'h5);
        bus(1'b1, 8'h0c, 32'h0);
        bus(1'b1, 8'h18, 32'h1);
        bus(1'b1, 8'h18, 32'h2);
        rd(8'h04, 32'h1);
        rd(8'h08, 32'h3e8);
        rd(8'h0c, 32'h10);
        rd(8'h18, 32'h0);
        // every fixed code, with width, parity, stop count and bit rate varied
        for (int i = 0; i < 6; i++) begin
            div = 16 + i;
            bus(1'b1, 8'h0c, 32'(div));
            setcfg({20'h0, 1'(i % 2), 1'b0, 3'(i % 5), 2'(3 - i % 4), 3'(i + 1), 2'h1});
            tx(8'h11);
            tx(codes[i]);
            get(8'h11, 1'b0, 2000);
            get(codes[i], 1'b1, 2000);
        end
        bus(1'b0, 8'h1c, 32'h0);
        check({29'h0, rdata[2:0]}, 32'h0);
        bus(1'b1, 8'h10, 32'h5859);
        bus(1'b1, 8'h14, 32'h2);
        setcfg(32'h61);
        tx(8'h58);
        tx(8'h51);
        tx(8'h58);
        tx(8'h59);
        get(8'h58, 1'b0, 2000);
        get(8'h51, 1'b0, 2000);
        get(8'h58, 1'b0, 2000);
        get(8'h59, 1'b1, 2000);
        bus(1'b1, 8'h04, 32'h1);
        bus(1'b1, 8'h08, 32'h7a120);
        setcfg(32'h66);
        tx(8'h55);
        get(8'h55, 1'b1, 30000);
        check(32'(waited >= 24000 && waited < 26000), 32'h1);
        // fill the buffer with the far side stalled, then drain
        bus(1'b1, 8'h08, 32'h3e8);
        setcfg(32'h464);
        for (int k = 0; k < 17; k++) tx(8'(8'h30 + k));
        repeat (2) @(posedge clk_i);
        check({31'h0, rts_n_o}, 32'h1);
        for (int k = 0; k < 16; k++) get(8'(8'h30 + k), 1'b0, 200);
        get(8'h40, 1'b1, 30000);
        bus(1'b0, 8'h1c, 32'h0);
        check({29'h0, rdata[2:0]}, 32'h0);
        conclude();
    end
endmodule : testbench

bind spd_delineator spd_delineator_asserts spd_delineator_asserts_inst (
    .clk_i(clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .rxd_i(rxd_i), .rts_n_o(rts_n_o),
    .pkt_data_o(pkt_data_o), .pkt_last_o(pkt_last_o), .pkt_valid_o(pkt_valid_o),
    .pkt_ready_i(pkt_ready_i));
`default_nettype wire
